/* logic/acic_pkg.sv */
// Overview of operation
// - Continuous mode stores each result and restarts conversion at once, no host action.
// - Single-shot waits for start flag, converts once, stores, clears flag, powers down.
// - Writing start flag during a running conversion is ignored; no restart.
// - Switching continuous to single-shot finishes current conversion, clears flag, powers down.
// - Power-up reset returns every configuration bit to its default.
// - Serial interface is an I2C slave only, never a master.
// - Bus lines are only pulled low or released, never driven high.
// - Transfers open with address plus direction bit; only own address is answered.
// - Three address bits come from two three-level straps; both floating is invalid.
// - Latest result held in a 16-bit two's complement register.
// - Result register reads zero after reset until the first conversion completes.
// - 8-bit configuration register, reset 80 hex, fields flag/mode/rate/gain.
// - In single-shot mode writing 1 to start flag starts, 0 does nothing.
// - In continuous mode the written start flag value is disregarded.
// - Continuous mode: flag reads 0 for unread result, 1 once read.
// - Single-shot mode: flag reads 1 while converting, 0 when done.
// - Mode bit 1 selects single-shot, 0 continuous; reset value 0.
// - Rate select: 480/240/60/30 samples per second at 12/13/15/16 bits.
// - Positive full-scale code limited to 2047/4095/16383/32767 by resolution.
// - Gain select gives amplifier gain 1, 2, 4 or 8.
// - Modulator and filter run from the internal oscillator clock.
// - Read returns result high, result low, then configuration; master may stop early.
// - Write loads only the first data byte into configuration; result not writable.
package acic_pkg;
    localparam logic [7:0] CFG_OFFSET = 8'h90;
    localparam logic [7:0] CFG_RESET = 8'h80;
    localparam int CFG_FLAG_BIT = 7;
    localparam int CFG_MODE_BIT = 4;
    localparam int CFG_RATE_LSB = 2;
    localparam int CFG_GAIN_LSB = 0;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [1:0] RD_LAST_BYTE = 2'h2;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Upper four address bits; value is arbitrary
    localparam logic [3:0] ADDR_HI_DEFAULT = 4'h9;
    localparam int OSC_HZ_DEFAULT = 8000000;
    localparam int RATE_SPS_R0 = 480;
    localparam int RATE_SPS_R1 = 240;
    localparam int RATE_SPS_R2 = 60;
    localparam int RATE_SPS_R3 = 30;
    localparam logic [15:0] FS_CODE_R0 = 16'h07FF;
    localparam logic [15:0] FS_CODE_R1 = 16'h0FFF;
    localparam logic [15:0] FS_CODE_R2 = 16'h3FFF;
    localparam logic [15:0] FS_CODE_R3 = 16'h7FFF;
    localparam int WIN_W = 19;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    typedef enum logic [1:0] {
        TRI_LOW = 2'b00,
        TRI_HIGH = 2'b01,
        TRI_FLOAT = 2'b10
    } acic_tri_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_ACK = 3'b010,
        S_ACKH = 3'b011,
        S_WRITE = 3'b100,
        S_READ = 3'b101,
        S_RACK = 3'b110
    } acic_i2c_st_t;

    typedef struct packed {
        logic single;
        logic [1:0] rate;
        logic [1:0] gain;
    } acic_cfg_t;
endpackage

/* logic/acic_top.sv */
`timescale 1ns/1ns
module acic_top #(
    parameter int OSC_HZ = acic_pkg::OSC_HZ_DEFAULT,
    parameter int CYC_R0 = OSC_HZ / acic_pkg::RATE_SPS_R0,
    parameter int CYC_R1 = OSC_HZ / acic_pkg::RATE_SPS_R1,
    parameter int CYC_R2 = OSC_HZ / acic_pkg::RATE_SPS_R2,
    parameter int CYC_R3 = OSC_HZ / acic_pkg::RATE_SPS_R3,
    parameter logic [3:0] ADDR_HI = acic_pkg::ADDR_HI_DEFAULT
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic conv_clk,
    input wire logic mod_bit,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire acic_pkg::acic_tri_t addr_strap_zero,
    input wire acic_pkg::acic_tri_t addr_strap_one,
    output acic_pkg::acic_cfg_t front_cfg,
    output logic power_down
);
    import acic_pkg::*;

    // Core domain: pin synchronisers
    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    acic_tri_t zero_s1, zero_s2, one_s1, one_s2;
    logic [1:0] strap_cnt_r;
    logic strap_done_r;
    logic [2:0] dev_addr_r;
    logic addr_ok_r;

    // Core domain: configuration and status
    acic_cfg_t cfg_r;
    logic flag_r;
    logic busy_r;
    logic start_tgl_r;
    logic done_s1, done_s2, done_d;
    logic [15:0] result_r;

    // Core domain: serial slave
    acic_i2c_st_t st_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic rw_r;
    logic [1:0] byte_idx_r;
    logic wr_first_r;
    logic [15:0] res_snap_r;

    // Oscillator domain
    logic cont_c1, cont_c2;
    logic st_c1, st_c2, st_prev_r;
    acic_cfg_t cfg_c1, cfg_c2;
    logic run_r;
    logic [WIN_W-1:0] win_cnt_r;
    logic signed [19:0] acc_r;
    acic_cfg_t cfg_l_r;
    logic [15:0] res_conv_r;
    logic done_tgl_r;

    logic scl_rise, scl_fall, start_det, stop_det;
    logic cfg_wr, start_req, mode_nxt, res_rd, done_pulse;
    logic [7:0] wr_byte;
    logic [7:0] cfg_rd;
    logic [7:0] tx_byte;

    assign scl_rise = scl_s2 & ~scl_d;
    assign scl_fall = ~scl_s2 & scl_d;
    assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;
    assign wr_byte = {shift_r[6:0], sda_s2};
    assign cfg_wr = (st_r == S_WRITE) & scl_rise & (bit_cnt_r == BIT_LAST) & wr_first_r;
    assign mode_nxt = cfg_wr ? wr_byte[CFG_MODE_BIT] : cfg_r.single;
    assign start_req = cfg_wr & wr_byte[CFG_MODE_BIT] & wr_byte[CFG_FLAG_BIT] & ~busy_r;
    // Marked read when the config byte is loaded, or on a NACK after the result low byte, so the config byte still says whether the result was fresh
    assign res_rd = (rw_r & scl_fall & (st_r == S_ACKH) & (byte_idx_r == RD_LAST_BYTE))
        | (rw_r & scl_rise & (st_r == S_RACK) & (byte_idx_r == 2'h1) & sda_s2);
    assign done_pulse = done_s2 ^ done_d;
    assign cfg_rd = {flag_r, 2'b00, cfg_r.single, cfg_r.rate, cfg_r.gain};

    always_comb begin
        unique case (byte_idx_r)
            2'h0: tx_byte = res_snap_r[15:8];
            2'h1: tx_byte = res_snap_r[7:0];
            default: tx_byte = cfg_rd;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
            zero_s1 <= TRI_LOW;
            zero_s2 <= TRI_LOW;
            one_s1 <= TRI_LOW;
            one_s2 <= TRI_LOW;
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_d <= 1'b0;
        end else begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
            zero_s1 <= addr_strap_zero;
            zero_s2 <= zero_s1;
            one_s1 <= addr_strap_one;
            one_s2 <= one_s1;
            done_s1 <= done_tgl_r;
            done_s2 <= done_s1;
            done_d <= done_s2;
        end
    end

    // Straps are caught once, after the synchronisers have filled
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_cnt_r <= 2'h0;
            strap_done_r <= 1'b0;
            dev_addr_r <= 3'h0;
            addr_ok_r <= 1'b0;
        end else if (!strap_done_r) begin
            if (strap_cnt_r == STRAP_SETTLE) begin
                strap_done_r <= 1'b1;
                addr_ok_r <= ~(zero_s2 == TRI_FLOAT && one_s2 == TRI_FLOAT);
                if (zero_s2 == TRI_FLOAT) begin
                    dev_addr_r <= (one_s2 == TRI_HIGH) ? 3'h7 : 3'h3;
                end else begin
                    dev_addr_r[2] <= (zero_s2 == TRI_HIGH);
                    dev_addr_r[1:0] <= (one_s2 == TRI_FLOAT) ? 2'h2 : {1'b0, one_s2 == TRI_HIGH};
                end
            end else begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= acic_cfg_t'(CFG_RESET[CFG_MODE_BIT:CFG_GAIN_LSB]);
            flag_r <= CFG_RESET[CFG_FLAG_BIT];
            busy_r <= 1'b0;
            start_tgl_r <= 1'b0;
        end else begin
            if (cfg_wr) begin
                cfg_r <= acic_cfg_t'(wr_byte[CFG_MODE_BIT:CFG_GAIN_LSB]);
            end
            if (start_req) begin
                start_tgl_r <= ~start_tgl_r;
            end
            // Continuous mode keeps the converter busy for good
            if (!mode_nxt) begin
                busy_r <= 1'b1;
            end else if (start_req) begin
                busy_r <= 1'b1;
            end else if (done_pulse) begin
                busy_r <= 1'b0;
            end
            if (mode_nxt) begin
                if (start_req) begin
                    flag_r <= 1'b1;
                end else if (done_pulse) begin
                    flag_r <= 1'b0;
                end else if (cfg_wr && !cfg_r.single) begin
                    flag_r <= busy_r;
                end
            end else begin
                // Fresh data wins over a read in the same cycle
                if (done_pulse) begin
                    flag_r <= 1'b0;
                end else if (res_rd) begin
                    flag_r <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_r <= RESULT_RESET;
            front_cfg <= acic_cfg_t'(CFG_RESET[CFG_MODE_BIT:CFG_GAIN_LSB]);
            power_down <= 1'b0;
        end else begin
            if (done_pulse) begin
                result_r <= res_conv_r;
            end
            front_cfg <= cfg_r;
            power_down <= cfg_r.single & ~busy_r;
        end
    end

    // Slave only: no clock generation, and sda is only pulled low or released
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= S_IDLE;
            bit_cnt_r <= 3'h0;
            shift_r <= 8'h00;
            rw_r <= 1'b0;
            byte_idx_r <= 2'h0;
            wr_first_r <= 1'b0;
            res_snap_r <= RESULT_RESET;
            sda_oe_n <= 1'b1;
        end else if (start_det) begin
            st_r <= S_ADDR;
            bit_cnt_r <= 3'h0;
            sda_oe_n <= 1'b1;
        end else if (stop_det) begin
            st_r <= S_IDLE;
            sda_oe_n <= 1'b1;
        end else begin
            unique case (st_r)
                S_IDLE: begin
                    sda_oe_n <= 1'b1;
                end
                S_ADDR: begin
                    if (scl_rise) begin
                        shift_r <= wr_byte;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == BIT_LAST) begin
                            // Foreign or invalid address: stay silent until next start
                            if (addr_ok_r && shift_r[6:0] == {ADDR_HI, dev_addr_r}) begin
                                st_r <= S_ACK;
                                rw_r <= sda_s2;
                                byte_idx_r <= 2'h0;
                                wr_first_r <= 1'b1;
                                res_snap_r <= result_r;
                            end else begin
                                st_r <= S_IDLE;
                            end
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        sda_oe_n <= 1'b0;
                        st_r <= S_ACKH;
                    end
                end
                S_ACKH: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 3'h0;
                        if (rw_r) begin
                            sda_oe_n <= tx_byte[7];
                            shift_r <= {tx_byte[6:0], 1'b0};
                            st_r <= S_READ;
                        end else begin
                            sda_oe_n <= 1'b1;
                            st_r <= S_WRITE;
                        end
                    end
                end
                S_WRITE: begin
                    if (scl_rise) begin
                        shift_r <= wr_byte;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == BIT_LAST) begin
                            // Later bytes are acknowledged but dropped
                            wr_first_r <= 1'b0;
                            st_r <= S_ACK;
                        end
                    end
                end
                S_READ: begin
                    if (scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_r == 3'h0) begin
                            sda_oe_n <= 1'b1;
                            st_r <= S_RACK;
                        end else begin
                            sda_oe_n <= shift_r[7];
                            shift_r <= {shift_r[6:0], 1'b0};
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        if (sda_s2) begin
                            st_r <= S_IDLE;
                        end else begin
                            st_r <= S_ACKH;
                            if (byte_idx_r != RD_LAST_BYTE) begin
                                byte_idx_r <= byte_idx_r + 2'h1;
                            end
                        end
                    end
                end
                default: begin
                    st_r <= S_IDLE;
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // Oscillator domain: mode and settings arrive as synchronised levels, start as a toggle
    always_ff @(posedge conv_clk or negedge arst_n) begin
        if (!arst_n) begin
            cont_c1 <= 1'b0;
            cont_c2 <= 1'b0;
            st_c1 <= 1'b0;
            st_c2 <= 1'b0;
            cfg_c1 <= acic_cfg_t'(CFG_RESET[CFG_MODE_BIT:CFG_GAIN_LSB]);
            cfg_c2 <= acic_cfg_t'(CFG_RESET[CFG_MODE_BIT:CFG_GAIN_LSB]);
        end else begin
            cont_c1 <= ~cfg_r.single;
            cont_c2 <= cont_c1;
            st_c1 <= start_tgl_r;
            st_c2 <= st_c1;
            cfg_c1 <= cfg_r;
            cfg_c2 <= cfg_c1;
        end
    end

    function automatic logic [WIN_W-1:0] win_len(input logic [1:0] rate);
        unique case (rate)
            2'h0: win_len = WIN_W'(CYC_R0 - 1);
            2'h1: win_len = WIN_W'(CYC_R1 - 1);
            2'h2: win_len = WIN_W'(CYC_R2 - 1);
            default: win_len = WIN_W'(CYC_R3 - 1);
        endcase
    endfunction

    function automatic logic [15:0] clamp_code(input logic signed [22:0] v, input logic [1:0] rate);
        logic signed [22:0] fs;
        logic signed [22:0] neg;
        unique case (rate)
            2'h0: fs = $signed({7'h00, FS_CODE_R0});
            2'h1: fs = $signed({7'h00, FS_CODE_R1});
            2'h2: fs = $signed({7'h00, FS_CODE_R2});
            default: fs = $signed({7'h00, FS_CODE_R3});
        endcase
        neg = -fs - 23'sd1;
        if (v > fs) begin
            clamp_code = fs[15:0];
        end else if (v < neg) begin
            clamp_code = neg[15:0];
        end else begin
            clamp_code = v[15:0];
        end
    endfunction

    // Up/down count of the modulator stream over one rate window is the decimated sample
    always_ff @(posedge conv_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_r <= 1'b0;
            win_cnt_r <= '0;
            acc_r <= '0;
            cfg_l_r <= acic_cfg_t'(CFG_RESET[CFG_MODE_BIT:CFG_GAIN_LSB]);
            res_conv_r <= RESULT_RESET;
            done_tgl_r <= 1'b0;
            st_prev_r <= 1'b0;
        end else if (!run_r) begin
            if (cont_c2 || (st_c2 != st_prev_r)) begin
                run_r <= 1'b1;
                st_prev_r <= st_c2;
                cfg_l_r <= cfg_c2;
                win_cnt_r <= win_len(cfg_c2.rate);
                acc_r <= '0;
            end
        end else begin
            acc_r <= mod_bit ? acc_r + 20'sd1 : acc_r - 20'sd1;
            if (win_cnt_r == '0) begin
                res_conv_r <= clamp_code(23'(acc_r) <<< cfg_l_r.gain, cfg_l_r.rate);
                done_tgl_r <= ~done_tgl_r;
                // A start toggle seen mid-conversion is absorbed, never queued
                st_prev_r <= st_c2;
                if (cont_c2) begin
                    cfg_l_r <= cfg_c2;
                    win_cnt_r <= win_len(cfg_c2.rate);
                    acc_r <= '0;
                end else begin
                    run_r <= 1'b0;
                end
            end else begin
                win_cnt_r <= win_cnt_r - WIN_W'(1);
            end
        end
    end
endmodule

/* bench/acic_top_sva.sv */
`timescale 1ns/1ns
module acic_top_sva (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic conv_clk,
    input wire logic mod_bit,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire acic_pkg::acic_tri_t addr_strap_zero,
    input wire acic_pkg::acic_tri_t addr_strap_one,
    input wire acic_pkg::acic_cfg_t front_cfg,
    input wire logic power_down
);
    import acic_pkg::*;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    AST_SDA_ONLY_LOW: assert property (!sda_o)
        else $error("data pin value not low");
    // Moving sda while scl is high would forge a start or stop
    AST_SDA_MOVES_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl_i)
        else $error("sda moved while scl high");
    AST_RESET_DEFAULTS: assert property ($rose(arst_n) |-> front_cfg == 5'h00 && !power_down && sda_oe_n)
        else $error("defaults wrong after reset");
    AST_CONT_NEVER_DOWN: assert property (!front_cfg.single [*4] |-> !power_down)
        else $error("powered down in continuous mode");
    AST_DOWN_ONLY_SINGLE: assert property ($rose(power_down) |-> front_cfg.single)
        else $error("power down outside single mode");
    AST_CFG_ON_SCL_HIGH: assert property ($changed(front_cfg) |-> scl_i && sda_oe_n)
        else $error("config changed outside a data bit");
    AST_WAKE_BY_WRITE: assert property ($fell(power_down) |-> scl_i || $past(scl_i))
        else $error("woke without a host write");
    AST_BIT_STANDS: assert property ($rose(scl_i) |=> $stable(sda_oe_n) [*3])
        else $error("driven bit not held over scl high");

    cover property ($rose(power_down));
    cover property ($fell(power_down));
    cover property ($fell(sda_oe_n));
    cover property ($changed(front_cfg));
endmodule

bind acic_top acic_top_sva i_acic_top_sva (
    .core_clk(core_clk), .arst_n(arst_n), .conv_clk(conv_clk), .mod_bit(mod_bit),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .addr_strap_zero(addr_strap_zero), .addr_strap_one(addr_strap_one),
    .front_cfg(front_cfg), .power_down(power_down)
);

/* bench/acic_i2c_master.sv */
`timescale 1ns/1ns
module acic_i2c_master #(
    parameter int HALF = 16
) (
    input wire logic clk,
    input wire logic sda_in,
    output logic scl_low,
    output logic sda_low
);
    // Lines are only pulled low or released; pull-ups give the high level
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic hp();
        repeat (HALF) @(negedge clk);
    endtask
    // Sample just before the fall, where the slave bit has settled
    task automatic pulse(output logic s);
        hp();
        scl_low = 1'b0;
        hp();
        s = sda_in;
        scl_low = 1'b1;
    endtask
    task automatic start();
        hp();
        sda_low = 1'b1;
        hp();
        scl_low = 1'b1;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        hp();
        scl_low = 1'b0;
        hp();
        sda_low = 1'b0;
        hp();
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sda_low = ~b[i];
            pulse(s);
        end
        sda_low = 1'b0;
        pulse(s);
        ack = ~s;
    endtask
    task automatic rbyte(output logic [7:0] b, input logic last);
        logic s;
        sda_low = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pulse(s);
            b[i] = s;
        end
        sda_low = ~last;
        pulse(s);
    endtask
endmodule

/* bench/acic_top_tb.sv */
`timescale 1ns/1ns
module acic_top_tb;
    import acic_pkg::*;
    logic core_clk = 1'b0;
    logic conv_clk = 1'b0;
    logic arst_n = 1'b0;
    logic mod_bit = 1'b1;
    logic mod_set = 1'b1;
    acic_tri_t strap_z = TRI_LOW;
    acic_tri_t strap_o = TRI_LOW;
    logic sda_o, sda_oe_n, power_down, scl_low, sda_low, scl_line, sda_line, ack;
    acic_cfg_t front_cfg;
    logic [6:0] dev;
    logic [15:0] res;
    logic [7:0] cfg;
    logic [2:0] exp_a [9] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7, 3'h3};
    int n_fail = 0;
    int checked = 0;

    always #4 core_clk = ~core_clk;
    always begin
        #62 conv_clk = 1'b1;
        #63 conv_clk = 1'b0;
    end
    always @(negedge conv_clk) mod_bit <= mod_set;
    assign scl_line = ~scl_low;
    assign sda_line = ~(sda_low | (~sda_oe_n & ~sda_o));

    acic_top #(.CYC_R0(260), .CYC_R1(520), .CYC_R2(2100), .CYC_R3(4200)) i_acic_top (
        .core_clk(core_clk), .arst_n(arst_n), .conv_clk(conv_clk), .mod_bit(mod_bit),
        .scl_i(scl_line), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .addr_strap_zero(strap_z), .addr_strap_one(strap_o),
        .front_cfg(front_cfg), .power_down(power_down)
    );
    acic_i2c_master i_acic_i2c_master (
        .clk(core_clk), .sda_in(sda_line), .scl_low(scl_low), .sda_low(sda_low)
    );

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // A trailing byte is always sent so that a kept extra byte shows up
    task automatic wr(input logic [7:0] c);
        i_acic_i2c_master.start();
        i_acic_i2c_master.wbyte({dev, 1'b0}, ack);
        chk("write ack", 16'h0001, {15'h0, ack});
        i_acic_i2c_master.wbyte(c, ack);
        i_acic_i2c_master.wbyte(8'hFF, ack);
        i_acic_i2c_master.stop();
    endtask
    task automatic rd();
        i_acic_i2c_master.start();
        i_acic_i2c_master.wbyte({dev, 1'b1}, ack);
        if (ack) begin
            i_acic_i2c_master.rbyte(res[15:8], 1'b0);
            i_acic_i2c_master.rbyte(res[7:0], 1'b0);
            i_acic_i2c_master.rbyte(cfg, 1'b1);
        end
        i_acic_i2c_master.stop();
    endtask
    // Reset spans two oscillator edges so both domains see it
    task automatic do_reset();
        arst_n = 1'b0;
        repeat (2) @(negedge conv_clk);
        @(negedge core_clk);
        arst_n = 1'b1;
        repeat (20) @(negedge core_clk);
    endtask
    task automatic wait_pd(input int lim);
        int k;
        for (k = 0; k < lim && power_down !== 1'b1; k++) @(negedge core_clk);
        if (k == lim) begin
            n_fail++;
            final_report();
        end
    endtask
    // Polls until n fresh results in turn, so that ones from before a setting change are skipped
    task automatic wait_new(input int n);
        int k;
        repeat (n) begin
            for (k = 0; k < 12; k++) begin
                rd();
                if (cfg[7] === 1'b0) break;
            end
            if (k == 12) begin
                n_fail++;
                final_report();
            end
        end
    endtask

    initial begin
        repeat (99000) @(negedge core_clk);
        n_fail++;
        final_report();
    end

    initial begin
        for (int i = 0; i < 9; i++) begin
            strap_z = acic_tri_t'(i / 3);
            strap_o = acic_tri_t'(i % 3);
            dev = {ADDR_HI_DEFAULT, exp_a[i]};
            do_reset();
            rd();
            chk("strap ack", {15'h0, i != 8}, {15'h0, ack});
            if (ack) begin
                chk("reset result", 16'h0000, res);
                chk("reset config", 16'h0080, {8'h0, cfg});
            end
        end
        strap_z = TRI_HIGH;
        strap_o = TRI_FLOAT;
        dev = {ADDR_HI_DEFAULT, 3'h0};
        do_reset();
        rd();
        chk("foreign addr", 16'h0000, {15'h0, ack});
        dev = {ADDR_HI_DEFAULT, 3'h6};
        wr(8'h03);
        chk("front cfg", 16'h0003, {11'h0, front_cfg});
        wait_new(3);
        chk("pos full scale", 16'h07FF, res);
        chk("fresh flag", 16'h0003, {8'h0, cfg});
        rd();
        chk("read flag", 16'h0083, {8'h0, cfg});
        mod_set = 1'b0;
        wr(8'h07);
        wait_new(3);
        chk("neg full scale", 16'hF000, res);
        mod_set = 1'b1;
        wr(8'h13);
        wait_pd(12000);
        rd();
        chk("switch flag", 16'h0013, {8'h0, cfg});
        wr(8'h13);
        chk("zero start", 16'h0001, {15'h0, power_down});
        wr(8'h93);
        chk("started", 16'h0000, {15'h0, power_down});
        rd();
        chk("busy flag", 16'h0093, {8'h0, cfg});
        repeat (800) @(negedge core_clk);
        wr(8'h93);
        wait_pd(1200);
        rd();
        chk("single result", 16'h07FF, res);
        chk("done flag", 16'h0013, {8'h0, cfg});
        for (int i = 0; i < 4; i++) begin
            wr(8'h70 + 8'(i * 5));
            rd();
            chk("cfg fields", 16'h0010 + 16'(i * 5), {8'h0, cfg});
            chk("front fields", 16'h0010 + 16'(i * 5), {11'h0, front_cfg});
        end
        do_reset();
        chk("front reset", 16'h0000, {11'h0, front_cfg});
        rd();
        chk("rerun result", 16'h0000, res);
        chk("rerun config", 16'h0080, {8'h0, cfg});
        final_report();
    end
endmodule
